//--- design/sbl_brake_limit.v
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`include "sbl_defs.vh"
// Behaviour
// (R1) stopped servo-off: brake holds, motor off after stopped delay
// (R2) host sets stopped delay at least brake actuation delay
// (R3) moving servo-off: motor off, brake holds after running delay
// (R4) brake holds at delay expiry or speed under threshold
// (R5) threshold speed 30 to 3000, default 30
// (R6) warning output 1 follows selector, 0 is any warning
// (R7) host never writes reserved codes 3, 5, 6
// (R8) warning output 2 own selector, same encoding
// (R9) in-position flag 2 while error below range, default 10
// (R10) unit bit picks command or encoder units
// (R11) selector 0: both limits open raises limit error
// (R12) selector 0: open limit blocks its direction only
// (R13) selector 1, default, ignores both limits
// (R14) selector 2: either limit open raises limit error
// (R15) selector 0: active limit stops per stop mode
// (R16) stop mode 0 to 2, default 0
// (R17) dynamic brake, free-run, immediate stop; counter per mode; code clears the counter alike in all three modes
// (R18) stopped at speed 30 or less, then stays stopped
// (R19) out-of-range writes keep old value
module sbl_brake_limit #(
    parameter TICK_CYCLES = `SBL_TICK_CYCLES
) (
    clk,
    arst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    motor_speed,
    position_error,
    encoder_error,
    warning_flags,
    forward_limit_input,
    reverse_limit_input,
    brake_hold_output,
    motor_energize,
    second_in_position_flag,
    position_unit_encoder,
    warning_out_one,
    warning_out_two,
    limit_error,
    forward_block,
    reverse_block,
    decel_dynamic_brake,
    decel_free_run,
    decel_immediate,
    counter_clear,
    zero_force_blocked,
    irq
);
    input  wire        clk;
    input  wire        arst_n;
    input  wire [15:0] reg_addr;
    input  wire [31:0] reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [31:0] reg_rdata;
    input  wire [15:0] motor_speed;
    input  wire [31:0] position_error;
    input  wire [31:0] encoder_error;
    input  wire [13:0] warning_flags;
    input  wire        forward_limit_input;
    input  wire        reverse_limit_input;
    output reg         brake_hold_output;
    output reg         motor_energize;
    output reg         second_in_position_flag;
    output reg         position_unit_encoder;
    output reg         warning_out_one;
    output reg         warning_out_two;
    output reg         limit_error;
    output reg         forward_block;
    output reg         reverse_block;
    output reg         decel_dynamic_brake;
    output reg         decel_free_run;
    output reg         decel_immediate;
    output reg         counter_clear;
    output reg         zero_force_blocked;
    output reg         irq;

    // ===========================================================
    // reset release and pin synchronisers
    reg        rst_meta;
    reg        rst_n;
    reg  [1:0] fwd_sync;
    reg  [1:0] rev_sync;
    wire       fwd_open;
    wire       rev_open;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // limit pins are closed (high) in normal status
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_sync <= 2'b11;
            rev_sync <= 2'b11;
        end else begin
            fwd_sync <= {fwd_sync[0], forward_limit_input};
            rev_sync <= {rev_sync[0], reverse_limit_input};
        end
    end
    assign fwd_open = ~fwd_sync[1];
    assign rev_open = ~rev_sync[1];

    // ===========================================================
    // parameter registers
    reg [15:0] stop_dly;
    reg [15:0] run_dly;
    reg [15:0] brk_spd;
    reg [15:0] warn1_sel;
    reg [15:0] warn2_sel;
    reg [31:0] inpos2;
    reg [15:0] lim_sel;
    reg [15:0] lim_mode;
    reg        servo_on;
    reg [`SBL_IRQ_BITS-1:0] irq_stat;
    reg [`SBL_IRQ_BITS-1:0] irq_mask;
    wire [`SBL_IRQ_BITS-1:0] irq_evt;
    wire [15:0] wd;

    assign wd = reg_wdata[15:0];

    // out-of-range writes ignored
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_dly  <= `SBL_RST_STOP_DLY;
            run_dly   <= `SBL_RST_RUN_DLY;
            brk_spd   <= `SBL_RST_BRK_SPD;
            warn1_sel <= `SBL_RST_WARN_SEL;
            warn2_sel <= `SBL_RST_WARN_SEL;
            inpos2    <= `SBL_RST_INPOS2;
            lim_sel   <= `SBL_RST_LIM_SEL;
            lim_mode  <= `SBL_RST_LIM_MODE;
            servo_on  <= 1'b0;
            position_unit_encoder <= 1'b0;
            irq_mask  <= {`SBL_IRQ_BITS{1'b0}};
        end else if (reg_wr) begin
            case (reg_addr)
                `SBL_ADDR_STOP_DLY:
                    if (wd <= `SBL_MAX_DLY) stop_dly <= wd; // (R19)
                `SBL_ADDR_RUN_DLY:
                    if (wd <= `SBL_MAX_DLY) run_dly <= wd; // (R3)
                `SBL_ADDR_BRK_SPD:
                    if (wd >= `SBL_MIN_BRK_SPD && wd <= `SBL_MAX_BRK_SPD) brk_spd <= wd; // (R5)
                `SBL_ADDR_WARN1_SEL:
                    if (wd <= `SBL_MAX_WARN_SEL) warn1_sel <= wd; // (R19)
                `SBL_ADDR_WARN2_SEL:
                    if (wd <= `SBL_MAX_WARN_SEL) warn2_sel <= wd; // (R8)
                `SBL_ADDR_INPOS2:
                    if (reg_wdata <= `SBL_MAX_INPOS2) inpos2 <= reg_wdata; // (R19)
                `SBL_ADDR_LIM_SEL:
                    if (wd <= `SBL_MAX_LIM_SEL) lim_sel <= wd; // (R13)
                `SBL_ADDR_LIM_MODE:
                    if (wd <= `SBL_MAX_LIM_MODE) lim_mode <= wd; // (R16)
                `SBL_ADDR_CTRL: begin
                    servo_on              <= reg_wdata[`SBL_CTRL_SERVO_ON];
                    position_unit_encoder <= reg_wdata[`SBL_CTRL_ENC_UNIT]; // (R10)
                end
                `SBL_ADDR_IRQ_MASK:
                    irq_mask <= reg_wdata[`SBL_IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // sticky status: set beats same-cycle clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= {`SBL_IRQ_BITS{1'b0}};
            irq      <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~((reg_wr && reg_addr == `SBL_ADDR_IRQ_STAT) ?
                        reg_wdata[`SBL_IRQ_BITS-1:0] : {`SBL_IRQ_BITS{1'b0}})) | irq_evt;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    // ===========================================================
    // servo-off sequencer
    localparam ST_ON        = 3'd0;
    localparam ST_STOP_WAIT = 3'd1;
    localparam ST_RUN_WAIT  = 3'd2;
    localparam ST_OFF       = 3'd3;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg         tmr_load;
    reg  [15:0] tmr_val;
    wire        tmr_done;
    wire        moving;
    wire        below_thr;

    assign moving    = (motor_speed > `SBL_STOP_SPEED);
    assign below_thr = (motor_speed < brk_spd);

    sbl_ms_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_done)
    );

    always @* begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_val    = stop_dly;
        case (state)
            ST_ON: begin
                if (!servo_on) begin
                    tmr_load = 1'b1;
                    if (moving) begin
                        tmr_val    = run_dly; // (R3)
                        next_state = ST_RUN_WAIT;
                    end else begin
                        next_state = ST_STOP_WAIT; // (R1)
                    end
                end
            end
            ST_STOP_WAIT:
                if (servo_on) next_state = ST_ON;
                else if (tmr_done) next_state = ST_OFF; // (R1)
            ST_RUN_WAIT:
                if (tmr_done || below_thr) next_state = ST_OFF; // (R4)
            ST_OFF:
                if (servo_on) next_state = ST_ON;
            default: next_state = ST_OFF;
        endcase
    end

    // brake released with servo on and during the running delay
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state             <= ST_OFF;
            brake_hold_output <= 1'b1;
            motor_energize    <= 1'b0;
        end else begin
            state             <= next_state;
            brake_hold_output <= (next_state != ST_ON) && (next_state != ST_RUN_WAIT); // (R4)
            motor_energize    <= (next_state == ST_ON) || (next_state == ST_STOP_WAIT); // (R1)
        end
    end

    // ===========================================================
    // warnings, in-position, travel limits
    reg  [1:0] warn_hit;
    wire [15:0] sel [0:1];
    wire [31:0] err_sel;
    wire        lim_active;
    wire        lim_err_now;
    reg         stopped;
    genvar      gi;

    assign sel[0] = warn1_sel;
    assign sel[1] = warn2_sel;

    // code 0 is any warning
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_warn
            always @* begin
                if (sel[gi] == 16'h0000)
                    warn_hit[gi] = |warning_flags; // (R6)
                else
                    warn_hit[gi] = warning_flags[sel[gi][3:0]]; // (R8)
            end
        end
    endgenerate

    assign err_sel     = position_unit_encoder ? encoder_error : position_error; // (R10)
    assign lim_active  = (lim_sel == 16'h0000) && (fwd_open || rev_open); // (R15)
    assign lim_err_now = ((lim_sel == 16'h0000) && fwd_open && rev_open) || // (R11)
                         ((lim_sel == 16'h0002) && (fwd_open || rev_open)); // (R14)

    assign irq_evt = {warn_hit[1] & ~warning_out_two,
                      warn_hit[0] & ~warning_out_one,
                      (next_state == ST_OFF) & motor_energize,
                      (next_state != ST_ON && next_state != ST_RUN_WAIT) & ~brake_hold_output,
                      lim_err_now & ~limit_error};

    // stopped latches until limit clears
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stopped                 <= 1'b0;
            second_in_position_flag <= 1'b0;
            warning_out_one         <= 1'b0;
            warning_out_two         <= 1'b0;
            limit_error             <= 1'b0;
            forward_block           <= 1'b0;
            reverse_block           <= 1'b0;
            decel_dynamic_brake     <= 1'b0;
            decel_free_run          <= 1'b0;
            decel_immediate         <= 1'b0;
            counter_clear           <= 1'b0;
            zero_force_blocked      <= 1'b0;
        end else begin
            stopped <= lim_active && (stopped || !moving); // (R18)
            second_in_position_flag <= (err_sel < inpos2); // (R9)
            warning_out_one <= warn_hit[0]; // (R6)
            warning_out_two <= warn_hit[1]; // (R8)
            limit_error     <= lim_err_now; // (R11)
            forward_block   <= (lim_sel == 16'h0000) && fwd_open; // (R12)
            reverse_block   <= (lim_sel == 16'h0000) && rev_open; // (R12)
            decel_dynamic_brake <= lim_active && !stopped && lim_mode == 16'h0000; // (R17)
            decel_free_run      <= lim_active && !stopped && lim_mode == 16'h0001; // (R17)
            decel_immediate     <= lim_active && !stopped && lim_mode == 16'h0002; // (R17)
            // clear while decelerating, alike in all three modes, until stopped latches
            counter_clear <= lim_active && (!stopped ||
                             (lim_mode == 16'h0002 && !moving && !stopped)); // (R17)
            zero_force_blocked <= lim_active && stopped && lim_mode != 16'h0002; // (R17)
        end
    end

    // ===========================================================
    // read port, data one cycle after strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SBL_ADDR_STOP_DLY:  reg_rdata <= {16'h0000, stop_dly};
                `SBL_ADDR_RUN_DLY:   reg_rdata <= {16'h0000, run_dly};
                `SBL_ADDR_BRK_SPD:   reg_rdata <= {16'h0000, brk_spd};
                `SBL_ADDR_WARN1_SEL: reg_rdata <= {16'h0000, warn1_sel};
                `SBL_ADDR_WARN2_SEL: reg_rdata <= {16'h0000, warn2_sel};
                `SBL_ADDR_INPOS2:    reg_rdata <= inpos2;
                `SBL_ADDR_LIM_SEL:   reg_rdata <= {16'h0000, lim_sel};
                `SBL_ADDR_LIM_MODE:  reg_rdata <= {16'h0000, lim_mode};
                `SBL_ADDR_CTRL:      reg_rdata <= {30'h0000_0000, position_unit_encoder, servo_on};
                `SBL_ADDR_STATUS:    reg_rdata <= {24'h00_0000, second_in_position_flag,
                                                   limit_error, reverse_block, forward_block,
                                                   motor_energize, brake_hold_output, state[1:0]};
                `SBL_ADDR_IRQ_STAT:  reg_rdata <= {27'h000_0000, irq_stat};
                `SBL_ADDR_IRQ_MASK:  reg_rdata <= {27'h000_0000, irq_mask};
                default:             reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule // sbl_brake_limit

//--- design/sbl_defs.vh
`ifndef SBL_DEFS_VH
`define SBL_DEFS_VH
// ===========================================================
// register offsets
`define SBL_ADDR_STOP_DLY    16'h3437
`define SBL_ADDR_RUN_DLY     16'h3438
`define SBL_ADDR_BRK_SPD     16'h3439
`define SBL_ADDR_WARN1_SEL   16'h3440
`define SBL_ADDR_WARN2_SEL   16'h3441
`define SBL_ADDR_INPOS2      16'h3442
`define SBL_ADDR_LIM_SEL     16'h3504
`define SBL_ADDR_LIM_MODE    16'h3505
`define SBL_ADDR_CTRL        16'h3600
`define SBL_ADDR_STATUS      16'h3601
`define SBL_ADDR_IRQ_STAT    16'h3602
`define SBL_ADDR_IRQ_MASK    16'h3603
// ===========================================================
// reset values
`define SBL_RST_STOP_DLY     16'h0000
`define SBL_RST_RUN_DLY      16'h0000
`define SBL_RST_BRK_SPD      16'h001e
`define SBL_RST_WARN_SEL     16'h0000
`define SBL_RST_INPOS2       32'h0000_000a
`define SBL_RST_LIM_SEL      16'h0001
`define SBL_RST_LIM_MODE     16'h0000
// ===========================================================
// legal ranges
`define SBL_MAX_DLY          16'h2710
`define SBL_MIN_BRK_SPD      16'h001e
`define SBL_MAX_BRK_SPD      16'h0bb8
`define SBL_MAX_WARN_SEL     16'h000d
`define SBL_MAX_INPOS2       32'h0004_0000
`define SBL_MAX_LIM_SEL      16'h0002
`define SBL_MAX_LIM_MODE     16'h0002
`define SBL_STOP_SPEED       16'h001e
// ===========================================================
// timing: one millisecond tick at 100 MHz
`define SBL_TICK_NS          1000000
`define SBL_CLK_NS           10
`define SBL_TICK_CYCLES      (`SBL_TICK_NS / `SBL_CLK_NS)
// ===========================================================
// field positions
`define SBL_CTRL_SERVO_ON    0
`define SBL_CTRL_ENC_UNIT    1
`define SBL_IRQ_LIMIT_ERR    0
`define SBL_IRQ_BRAKE_HOLD   1
`define SBL_IRQ_DEENERGIZE   2
`define SBL_IRQ_WARN1        3
`define SBL_IRQ_WARN2        4
`define SBL_IRQ_BITS         5
`endif

//--- design/sbl_ms_timer.v
`timescale 1ns/1ns
`include "sbl_defs.vh"
// ===========================================================
// millisecond tick generator and down counter
module sbl_ms_timer #(
    parameter TICK_CYCLES = `SBL_TICK_CYCLES
) (
    clk,
    rst_n,
    load,
    load_val,
    expired
);
    input  wire        clk;
    input  wire        rst_n;
    input  wire        load;
    input  wire [15:0] load_val;
    output reg         expired;

    reg [31:0] tick_cnt;
    reg [15:0] ms_left;
    wire       tick;

    assign tick = (tick_cnt == TICK_CYCLES - 1);

    // prescaler restarts on load so a delay is never a tick short
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0000_0000;
            ms_left  <= 16'h0000;
            expired  <= 1'b0;
        end else if (load) begin
            tick_cnt <= 32'h0000_0000;
            ms_left  <= load_val;
            expired  <= (load_val == 16'h0000);
        end else begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            if (tick && ms_left != 16'h0000) begin
                ms_left <= ms_left - 16'h0001;
                expired <= (ms_left == 16'h0001);
            end
        end
    end
endmodule // sbl_ms_timer

//--- sim/sbl_motor_model.sv
`timescale 1ns/1ns
// ============================================================
// motor model
module sbl_motor_model (
    input  wire        clk,
    input  wire        motor_energize,
    input  wire [15:0] speed_cmd,
    output logic [15:0] motor_speed
);
    initial motor_speed = 16'h0000;
    // coasts down one unit a cycle once power is cut
    always @(posedge clk) begin
        if (motor_energize)
            motor_speed <= speed_cmd;
        else if (motor_speed != 16'h0000)
            motor_speed <= motor_speed - 16'h0001;
    end
endmodule // sbl_motor_model

//--- sim/sbl_checker.sv
`timescale 1ns/1ns
// ============================================================
// port checks
module sbl_checker (
    input wire        clk,
    input wire        arst_n,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire [15:0] motor_speed,
    input wire [31:0] position_error,
    input wire [13:0] warning_flags,
    input wire        forward_limit_input,
    input wire        reverse_limit_input,
    input wire        brake_hold_output,
    input wire        motor_energize,
    input wire        second_in_position_flag,
    input wire        position_unit_encoder,
    input wire        warning_out_one,
    input wire        warning_out_two,
    input wire        limit_error,
    input wire        forward_block,
    input wire        decel_dynamic_brake,
    input wire        decel_free_run,
    input wire        decel_immediate
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // read data only in the reply cycle
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside reply cycle");
    // threshold at default 30
    run_thresh_a: assert property (!motor_energize && !brake_hold_output
        && !$past(brake_hold_output) && motor_speed < 16'h001e |-> ##[1:4] brake_hold_output)
        else $error("brake late after speed drop");
    // a brake holding at power cut already held the cycle before
    stop_order_a: assert property ($fell(motor_energize) |->
        !brake_hold_output || $past(brake_hold_output))
        else $error("motor cut before brake held");
    // sync stages plus output register
    fwd_block_a: assert property (forward_block |-> !$past(forward_limit_input, 3))
        else $error("forward block without open input");
    lim_err_a: assert property (limit_error |->
        !$past(forward_limit_input, 3) || !$past(reverse_limit_input, 3))
        else $error("limit error, inputs closed");
    inpos_a: assert property (second_in_position_flag && !position_unit_encoder
        && !$past(position_unit_encoder) |-> $past(position_error) < 32'h0004_0000)
        else $error("in-position beyond range");
    warn_any_a: assert property (warning_out_one || warning_out_two |->
        $past(warning_flags) != 14'h0000)
        else $error("warning output with no warning active");
    decel_one_a: assert property ($onehot0({decel_dynamic_brake, decel_free_run,
        decel_immediate}))
        else $error("two deceleration methods");
endmodule // sbl_checker

bind sbl_brake_limit sbl_checker sbl_checker_inst (
    .clk, .arst_n, .reg_rd, .reg_rdata, .motor_speed, .position_error, .warning_flags,
    .forward_limit_input, .reverse_limit_input, .brake_hold_output, .motor_energize,
    .second_in_position_flag, .position_unit_encoder, .warning_out_one, .warning_out_two,
    .limit_error, .forward_block, .decel_dynamic_brake, .decel_free_run, .decel_immediate
);

//--- sim/tb_sbl_brake_limit.sv
`timescale 1ns/1ns
`include "sbl_defs.vh"
// ============================================================
// bench
module tb_sbl_brake_limit;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        rd_seen = 1'b0;
    logic [31:0] position_error = 32'h0000_0000;
    logic [31:0] encoder_error = 32'h0000_0000;
    logic [13:0] warning_flags = 14'h0000;
    logic        forward_limit_input = 1'b1;
    logic        reverse_limit_input = 1'b1;
    logic [15:0] speed_cmd = 16'h0000;
    logic [31:0] rng = 32'h0001_6a35;
    logic [31:0] exp_q [$];
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    wire  [31:0] reg_rdata;
    wire  [15:0] motor_speed;
    wire         brake_hold_output, motor_energize, second_in_position_flag, irq;
    wire         position_unit_encoder, warning_out_one, warning_out_two, limit_error;
    wire         forward_block, reverse_block, decel_dynamic_brake, decel_free_run;
    wire         decel_immediate, counter_clear, zero_force_blocked;
    logic [15:0] adr [8] = '{`SBL_ADDR_STOP_DLY, `SBL_ADDR_RUN_DLY, `SBL_ADDR_BRK_SPD,
        `SBL_ADDR_WARN1_SEL, `SBL_ADDR_WARN2_SEL, `SBL_ADDR_INPOS2, `SBL_ADDR_LIM_SEL,
        `SBL_ADDR_LIM_MODE};
    logic [31:0] rstv [8] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_001e, 32'h0000_0000,
        32'h0000_0000, 32'h0000_000a, 32'h0000_0001, 32'h0000_0000};
    logic [31:0] bad [8] = '{32'h0000_2711, 32'h0000_2711, 32'h0000_001d, 32'h0000_000e,
        32'h0000_000e, 32'h0004_0001, 32'h0000_0003, 32'h0000_0003};
    // 3 ms stop delay, brake needs 2
    logic [31:0] good [8] = '{32'h0000_0003, 32'h0000_2710, 32'h0000_001e, 32'h0000_000d,
        32'h0000_000d, 32'h0004_0000, 32'h0000_0002, 32'h0000_0002};
    int          legal [11] = '{0, 1, 2, 4, 7, 8, 9, 10, 11, 12, 13};

    sbl_brake_limit #(.TICK_CYCLES(10)) sbl_brake_limit_inst (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .motor_speed,
        .position_error, .encoder_error, .warning_flags, .forward_limit_input,
        .reverse_limit_input, .brake_hold_output, .motor_energize, .second_in_position_flag,
        .position_unit_encoder, .warning_out_one, .warning_out_two, .limit_error,
        .forward_block, .reverse_block, .decel_dynamic_brake, .decel_free_run,
        .decel_immediate, .counter_clear, .zero_force_blocked, .irq);
    sbl_motor_model sbl_motor_model_inst (.clk, .motor_energize, .speed_cmd, .motor_speed);

    always #5 clk = ~clk;
    // ========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic wexp(input int s, input logic [13:0] f);
        return (s == 0) ? |f : f[s];
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // oldest note against each reply
    always @(posedge clk) rd_seen <= reg_rd;
    always @(negedge clk) if (rd_seen) check("reg_rdata", reg_rdata, exp_q.pop_front());
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    // ========================================================
    // main sequence
    initial begin
        bit f;
        bit r;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        cycles(3);
        rd(16'h0000, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            rd(adr[i], rstv[i]);
            wr(adr[i], bad[i]);
            rd(adr[i], rstv[i]);
            wr(adr[i], good[i]);
            rd(adr[i], good[i]);
        end
        position_error <= 32'h0003_ffff;
        cycles(3);
        check("inpos2", second_in_position_flag, 1);
        position_error <= 32'h0004_0000;
        cycles(3);
        check("inpos2", second_in_position_flag, 0);
        encoder_error <= 32'h0000_0005;
        wr(`SBL_ADDR_CTRL, 3);
        cycles(3);
        check("unit", position_unit_encoder, 1);
        check("inpos2", second_in_position_flag, 1);
        for (int k = 0; k < 11; k++) begin
            wr(`SBL_ADDR_WARN1_SEL, legal[k]);
            wr(`SBL_ADDR_WARN2_SEL, legal[(k + 5) % 11]);
            rng = xs(rng);
            warning_flags <= rng[13:0];
            cycles(3);
            check("warn1", warning_out_one, wexp(legal[k], rng[13:0]));
            check("warn2", warning_out_two, wexp(legal[(k + 5) % 11], rng[13:0]));
        end
        // limit pairings
        for (int s = 0; s < 3; s++) begin
            wr(`SBL_ADDR_LIM_SEL, s);
            for (int k = 0; k < 4; k++) begin
                forward_limit_input <= k[0];
                reverse_limit_input <= k[1];
                cycles(6);
                f = !k[0];
                r = !k[1];
                check("lim_err", limit_error, s == 0 ? f & r : s == 2 ? f | r : 0);
                check("fwd_blk", forward_block, s == 0 && f);
                check("rev_blk", reverse_block, s == 0 && r);
            end
        end
        wr(`SBL_ADDR_LIM_SEL, 0);
        for (int m = 0; m < 3; m++) begin
            wr(`SBL_ADDR_LIM_MODE, m);
            speed_cmd <= 16'h0064;
            cycles(4);
            forward_limit_input <= 1'b0;
            cycles(6);
            check("decel", {decel_immediate, decel_free_run, decel_dynamic_brake}, 1 << m);
            check("clr", counter_clear, 1);
            speed_cmd <= 16'h0014;
            cycles(6);
            check("zero_force", zero_force_blocked, m != 2);
            check("clr", counter_clear, 0);
            speed_cmd <= 16'h0064;
            cycles(6);
            check("zero_force", zero_force_blocked, m != 2);
            forward_limit_input <= 1'b1;
        end
        wr(`SBL_ADDR_LIM_SEL, 1);
        // stopped servo-off, 3 ms
        speed_cmd <= 16'h0000;
        cycles(3);
        wr(`SBL_ADDR_CTRL, 2);
        cycles(2);
        check("brake", brake_hold_output, 1);
        check("energize", motor_energize, 1);
        cycles(24);
        check("energize", motor_energize, 1);
        cycles(8);
        check("energize", motor_energize, 0);
        // running servo-off: speed first, then 5 ms first
        speed_cmd <= 16'h003c;
        for (int j = 0; j < 2; j++) begin
            wr(`SBL_ADDR_CTRL, 3);
            cycles(3);
            wr(`SBL_ADDR_CTRL, 2);
            cycles(2);
            check("energize", motor_energize, 0);
            check("brake", brake_hold_output, 0);
            cycles(22 + j * 16);
            check("brake", brake_hold_output, 0);
            cycles(20);
            check("brake", brake_hold_output, 1);
            wr(`SBL_ADDR_RUN_DLY, 5);
            speed_cmd <= 16'h00c8;
        end
        // interrupt
        warning_flags <= 14'h0000;
        wr(`SBL_ADDR_IRQ_MASK, 0);
        cycles(2);
        check("irq", irq, 0);
        wr(`SBL_ADDR_IRQ_MASK, 32'h0000_0002);
        cycles(2);
        check("irq", irq, 1);
        wr(`SBL_ADDR_IRQ_STAT, 32'h0000_001f);
        cycles(2);
        check("irq", irq, 0);
        rd(`SBL_ADDR_IRQ_STAT, 32'h0000_0000);
        cycles(2);
        complete_run();
    end
endmodule // tb_sbl_brake_limit
